// ---- hdl/strap_cfg_pkg.sv ----
// constants for the power switch strap and multifunction pin block
package strap_cfg_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] REG_STRAP = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_PORT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_ADDR = 8'h10;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int STRAP_FPM = 0;
    localparam int STRAP_POL = 1;
    localparam int STRAP_GANG = 2;
    localparam int STRAP_MGMT = 3;
    localparam int STRAP_AUTO = 4;
    localparam int STRAP_LATCHED = 5;

    localparam int CFG_STS_EN = 0;
    localparam int CFG_ALL_CHG = 1;

    localparam int PORT_PWR_LSB = 0;
    localparam int PORT_CHG_LSB = 4;

    localparam int STAT_OC_LSB = 0;
    localparam int STAT_SS = 4;
    localparam int STAT_HS = 5;
    localparam int STAT_AUTO_ACT = 6;
    localparam int STAT_PROFILE_LSB = 8;

    localparam int ADDR_BIT1 = 1;
    localparam int ADDR_BIT2 = 2;

    // ************************************************************
    // sizes, encodings and reset values
    // ************************************************************
    localparam int NUM_PORTS = 4;
    localparam int PROFILE_W = 3;

    localparam logic [2:0] PROFILE_NONE = 3'h0;
    localparam logic [2:0] PROFILE_HIGH = 3'h4;
    localparam logic [2:0] PROFILE_ALL = 3'h7;

    // base slave address, value is arbitrary
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h44;

    localparam logic RST_STRAP = 1'b1;
    localparam logic RST_POL = 1'b1;
    localparam logic [3:0] RST_PORT = 4'h0;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic {
        PH_STRAP = 1'b0,
        PH_RUN = 1'b1
    } phase_e;

endpackage

// ---- hdl/power_switch_strap_config.sv ----
// strap latch, port power switching and status pin logic of the hub
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps

// Overview of operation
// - latch power management strap, low enables switching
// - strap initialises all-charge-modes bit
// - auto strap 0, bit 0: all profiles
// - auto strap 0, bit 1: highest profile only
// - smbus mode: address bit 1 from strap
// - status enable drives superspeed connect status
// - latch polarity strap, 0 low, 1 high
// - latch gang strap, 1 gangs all ports
// - smbus mode: address bit 2 from gang
// - status enable drives highspeed connect status
// - switch four ports via power, charge outputs
// - latch bus select strap, 1 is i2c
// - latch auto charge strap, 0 enables auto
module power_switch_strap_config
    import strap_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic full_power_mgmt_strap_i,
    output logic superspeed_link_status_o,
    output logic superspeed_link_status_oe_o,
    input wire logic gang_strap_i,
    output logic highspeed_link_status_o,
    output logic highspeed_link_status_oe_o,
    input wire logic power_ctrl_polarity_strap_i,
    input wire logic mgmt_bus_select_strap_i,
    input wire logic auto_charge_strap_i,
    input wire logic ss_connected_i,
    input wire logic hs_connected_i,
    input wire logic [3:0] overcurrent_n_i,
    output logic [3:0] port_power_ctrl_o,
    output logic [3:0] port_charge_enable_o,
    output logic [3:0] overcurrent_o,
    output logic [2:0] divider_charge_profile_o,
    output logic auto_charge_active_o,
    output logic [6:0] slave_addr_o,
    output logic i2c_mode_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        phase_e phase;
        logic fpm;
        logic pol;
        logic gang;
        logic mgmt;
        logic autoz;
        logic sts_en;
        logic all_chg;
        logic [3:0] pwr_req;
        logic [3:0] chg_req;
        logic ack;
        logic [31:0] dat;
        logic ss_out;
        logic ss_oe;
        logic hs_out;
        logic hs_oe;
        logic [3:0] pwr;
        logic [3:0] chg;
        logic [3:0] oc;
        logic [2:0] profile;
        logic auto_act;
        logic [6:0] addr;
        logic i2c;
    } state_s;

    state_s s;
    state_s next_s;

    // logical on/off to pin level for the latched polarity
    function automatic logic [3:0] apply_pol(input logic [3:0] on,
                                             input logic pol);
        apply_pol = pol ? on : ~on;
    endfunction

    function automatic logic [31:0] read_mux(input state_s st,
                                             input logic [7:0] adr);
        read_mux = RD_ZERO;
        case (adr)
            REG_STRAP: begin
                read_mux[STRAP_FPM] = st.fpm;
                read_mux[STRAP_POL] = st.pol;
                read_mux[STRAP_GANG] = st.gang;
                read_mux[STRAP_MGMT] = st.mgmt;
                read_mux[STRAP_AUTO] = st.autoz;
                read_mux[STRAP_LATCHED] = (st.phase == PH_RUN);
            end
            REG_CONFIG: begin
                read_mux[CFG_STS_EN] = st.sts_en;
                read_mux[CFG_ALL_CHG] = st.all_chg;
            end
            REG_PORT: begin
                read_mux[PORT_PWR_LSB +: NUM_PORTS] = st.pwr_req;
                read_mux[PORT_CHG_LSB +: NUM_PORTS] = st.chg_req;
            end
            REG_STATUS: begin
                read_mux[STAT_OC_LSB +: NUM_PORTS] = st.oc;
                read_mux[STAT_SS] = st.ss_out;
                read_mux[STAT_HS] = st.hs_out;
                read_mux[STAT_AUTO_ACT] = st.auto_act;
                read_mux[STAT_PROFILE_LSB +: PROFILE_W] = st.profile;
            end
            REG_ADDR: begin
                read_mux[6:0] = st.addr;
            end
            default: begin
                read_mux = RD_ZERO;
            end
        endcase
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic run;
        logic fpm_on;
        logic [3:0] req_eff;
        logic [3:0] oc_raw;
        run = 1'b0;
        fpm_on = 1'b0;
        req_eff = RST_PORT;
        oc_raw = RST_PORT;
        next_s = s;
        run = (s.phase == PH_RUN);
        fpm_on = run && !s.fpm;

        // bus slave: one ack per request, unmapped reads zero
        next_s.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.dat = read_mux(s, wb_adr_i);
            if (wb_we_i && wb_sel_i[0]) begin
                case (wb_adr_i)
                    REG_CONFIG: begin
                        next_s.sts_en = wb_dat_i[CFG_STS_EN];
                        next_s.all_chg = wb_dat_i[CFG_ALL_CHG];
                    end
                    REG_PORT: begin
                        next_s.pwr_req = wb_dat_i[PORT_PWR_LSB +: NUM_PORTS];
                        next_s.chg_req = wb_dat_i[PORT_CHG_LSB +: NUM_PORTS];
                    end
                    default: begin
                        next_s.sts_en = s.sts_en;
                    end
                endcase
            end
        end

        case (s.phase)
            PH_STRAP: begin
                next_s.fpm = full_power_mgmt_strap_i;
                next_s.pol = power_ctrl_polarity_strap_i;
                next_s.gang = gang_strap_i;
                next_s.mgmt = mgmt_bus_select_strap_i;
                next_s.autoz = auto_charge_strap_i;
                // seed all-charge bit; latch beats a same-cycle write
                next_s.all_chg = full_power_mgmt_strap_i;
                next_s.phase = PH_RUN;
            end
            PH_RUN: begin
                next_s.phase = PH_RUN;
            end
            default: begin
                next_s.phase = PH_STRAP;
            end
        endcase

        req_eff = s.gang ? {NUM_PORTS{s.pwr_req[0]}} : s.pwr_req;
        next_s.pwr = apply_pol(fpm_on ? req_eff : RST_PORT, s.pol);
        next_s.chg = fpm_on ? s.chg_req : RST_PORT;
        // over-current ignored while switching is not supported
        oc_raw = ~overcurrent_n_i;
        if (!fpm_on) begin
            next_s.oc = RST_PORT;
        end else if (s.gang) begin
            next_s.oc = {NUM_PORTS{|oc_raw}};
        end else begin
            next_s.oc = oc_raw;
        end

        if (!run || s.autoz) begin
            next_s.profile = PROFILE_NONE;
        end else if (s.all_chg) begin
            next_s.profile = PROFILE_HIGH;
        end else begin
            next_s.profile = PROFILE_ALL;
        end
        // auto charging only while the hub is unconnected
        next_s.auto_act = run && !s.autoz && fpm_on &&
                          !(ss_connected_i || hs_connected_i);

        next_s.ss_oe = run && s.sts_en;
        next_s.ss_out = ss_connected_i;
        next_s.hs_oe = run && s.sts_en;
        next_s.hs_out = hs_connected_i;

        next_s.addr = SLAVE_ADDR_BASE;
        if (!s.mgmt) begin
            next_s.addr[ADDR_BIT1] = s.fpm;
            next_s.addr[ADDR_BIT2] = s.gang;
        end
        next_s.i2c = s.mgmt;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.phase <= PH_STRAP;
            s.fpm <= RST_STRAP;
            s.pol <= RST_POL;
            s.mgmt <= RST_STRAP;
            s.autoz <= RST_STRAP;
            s.all_chg <= RST_STRAP;
            s.addr <= SLAVE_ADDR_BASE;
            s.i2c <= RST_STRAP;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign superspeed_link_status_o = s.ss_out;
    assign superspeed_link_status_oe_o = s.ss_oe;
    assign highspeed_link_status_o = s.hs_out;
    assign highspeed_link_status_oe_o = s.hs_oe;
    assign port_power_ctrl_o = s.pwr;
    assign port_charge_enable_o = s.chg;
    assign overcurrent_o = s.oc;
    assign divider_charge_profile_o = s.profile;
    assign auto_charge_active_o = s.auto_act;
    assign slave_addr_o = s.addr;
    assign i2c_mode_o = s.i2c;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence latch_edge;
        (s.phase == PH_STRAP) ##1 (s.phase == PH_RUN);
    endsequence

    sequence running_ss_en;
        (s.phase == PH_RUN) && s.sts_en;
    endsequence

    a_fpm_latch: assert property (latch_edge |->
        s.fpm == $past(full_power_mgmt_strap_i))
        else $error("power management strap not latched");
    a_all_chg_seed: assert property (latch_edge |->
        s.all_chg == $past(full_power_mgmt_strap_i))
        else $error("all-charge bit not seeded");
    a_profile_all: assert property (
        (s.phase == PH_RUN) && !s.autoz && !s.all_chg |=>
        divider_charge_profile_o == PROFILE_ALL)
        else $error("all profiles not allowed");
    a_profile_high: assert property (
        (s.phase == PH_RUN) && !s.autoz && s.all_chg |=>
        divider_charge_profile_o == PROFILE_HIGH)
        else $error("highest profile not chosen");
    a_addr_bit1: assert property (!s.mgmt |=>
        slave_addr_o[ADDR_BIT1] == $past(s.fpm))
        else $error("address bit 1 wrong");
    a_ss_drive: assert property (running_ss_en |=>
        superspeed_link_status_oe_o &&
        superspeed_link_status_o == $past(ss_connected_i))
        else $error("superspeed status not driven");
    a_pol_latch: assert property (latch_edge |->
        s.pol == $past(power_ctrl_polarity_strap_i))
        else $error("polarity strap not latched");
    a_gang_follow: assert property (
        (s.phase == PH_RUN) && !s.fpm && s.gang |=>
        port_power_ctrl_o == {NUM_PORTS{port_power_ctrl_o[0]}})
        else $error("ganged ports differ");
    a_addr_bit2: assert property (!s.mgmt |=>
        slave_addr_o[ADDR_BIT2] == $past(s.gang))
        else $error("address bit 2 wrong");
    a_hs_drive: assert property (running_ss_en |=>
        highspeed_link_status_oe_o &&
        highspeed_link_status_o == $past(hs_connected_i))
        else $error("highspeed status not driven");
    a_pwr_off: assert property (
        (s.phase == PH_RUN) && s.fpm |=>
        port_power_ctrl_o == {NUM_PORTS{!$past(s.pol)}} &&
        port_charge_enable_o == RST_PORT)
        else $error("ports powered without switching");
    a_mgmt_latch: assert property (latch_edge |->
        s.mgmt == $past(mgmt_bus_select_strap_i) ##1 i2c_mode_o == s.mgmt)
        else $error("bus select strap not latched");
    a_auto_latch: assert property (latch_edge |->
        s.autoz == $past(auto_charge_strap_i))
        else $error("auto charge strap not latched");
    a_strap_hold: assert property (
        (s.phase == PH_RUN) ##1 (s.phase == PH_RUN) |->
        $stable({s.fpm, s.pol, s.gang, s.mgmt, s.autoz}))
        else $error("strap changed after latch");
    a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // ************************************************************
    // mode side effects of the latched straps
    // ************************************************************
    // one shared fault line in gang mode, so any port trips all
    a_oc_gang: assert property (
        (s.phase == PH_RUN) && !s.fpm && s.gang |=>
        overcurrent_o == {NUM_PORTS{|$past(~overcurrent_n_i)}})
        else $error("ganged over-current not merged");
    a_auto_idle: assert property (
        (s.phase == PH_RUN) && s.autoz |=> !auto_charge_active_o)
        else $error("auto charging with strap disabled");
    // i2c mode keeps the base address, strap pins not used
    a_i2c_addr: assert property (
        (s.phase == PH_RUN) && s.mgmt |=>
        slave_addr_o == SLAVE_ADDR_BASE)
        else $error("address altered in i2c mode");

endmodule // power_switch_strap_config

// ---- tb/board_model.sv ----
// board strap resistors and downstream power switches
`timescale 1ns/10ps
module board_model (
    input wire logic [4:0] strap_set_i,
    input wire logic [3:0] fault_i,
    input wire logic pol_i,
    input wire logic [3:0] pwr_i,
    input wire logic ss_out_i,
    input wire logic ss_oe_i,
    input wire logic hs_out_i,
    input wire logic hs_oe_i,
    output logic fpm_pin_o,
    output logic pol_pin_o,
    output logic gang_pin_o,
    output logic mgmt_pin_o,
    output logic auto_pin_o,
    output logic [3:0] oc_n_o
);
    // ************************************************************
    // strap pins
    // ************************************************************
    // board strap levels
    // shared pins: the hub output wins over the strap once enabled
    assign fpm_pin_o = ss_oe_i ? ss_out_i : strap_set_i[0];
    assign pol_pin_o = strap_set_i[1];
    assign gang_pin_o = hs_oe_i ? hs_out_i : strap_set_i[2];
    assign mgmt_pin_o = strap_set_i[3];
    assign auto_pin_o = strap_set_i[4];
    // ************************************************************
    // power switches
    // ************************************************************
    // a switch only reports a fault while it is powered
    assign oc_n_o = ~(fault_i & ~(pwr_i ^ {4{pol_i}}));
endmodule // board_model

// ---- tb/power_switch_strap_config_tb.sv ----
// testbench for the strap latch and port power block
`timescale 1ns/10ps
module power_switch_strap_config_tb;
    import strap_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ss_c = 1'b0;
    logic hs_c = 1'b0;
    logic [4:0] straps = 5'h00;
    logic [3:0] fault = 4'h0;
    logic [31:0] rdat, q;
    logic ack, fpm_p, pol_p, gang_p, mgmt_p, auto_p;
    logic ss_o, ss_oe, hs_o, hs_oe, auto_act, i2c;
    logic [3:0] oc_n, pwr, chg, oc;
    logic [2:0] prof;
    logic [6:0] saddr;
    int bad_count = 0;
    int cmp_count = 0;

    power_switch_strap_config uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .full_power_mgmt_strap_i(fpm_p), .superspeed_link_status_o(ss_o),
        .superspeed_link_status_oe_o(ss_oe), .gang_strap_i(gang_p),
        .highspeed_link_status_o(hs_o), .highspeed_link_status_oe_o(hs_oe),
        .power_ctrl_polarity_strap_i(pol_p),
        .mgmt_bus_select_strap_i(mgmt_p), .auto_charge_strap_i(auto_p),
        .ss_connected_i(ss_c), .hs_connected_i(hs_c),
        .overcurrent_n_i(oc_n), .port_power_ctrl_o(pwr),
        .port_charge_enable_o(chg), .overcurrent_o(oc),
        .divider_charge_profile_o(prof), .auto_charge_active_o(auto_act),
        .slave_addr_o(saddr), .i2c_mode_o(i2c));

    board_model board (.strap_set_i(straps), .fault_i(fault),
        .pol_i(straps[1]), .pwr_i(pwr), .ss_out_i(ss_o), .ss_oe_i(ss_oe),
        .hs_out_i(hs_o), .hs_oe_i(hs_oe), .fpm_pin_o(fpm_p),
        .pol_pin_o(pol_p), .gang_pin_o(gang_p), .mgmt_pin_o(mgmt_p),
        .auto_pin_o(auto_p), .oc_n_o(oc_n));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task finish_test;
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task wb(input logic [7:0] a, input logic [31:0] d, input logic w,
            input logic [3:0] s);
        int n;
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        we <= w;
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        // ack is registered: seen at the second edge of the request
        chk("wb_ack_o", 32'd2, n);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(a, 32'h0, 1'b0, 4'hf);
        chk("wb_dat_o", e, q);
    endtask

    // outputs follow one cycle after their cause
    task settle;
        repeat (2) @(posedge clk_i);
    endtask

    task cfg(input logic [4:0] s);
        @(posedge clk_i);
        straps <= s;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        #100000;
        bad_count++;
        finish_test;
    end

    initial begin
        cfg(5'h02);
        rd(REG_STRAP, 32'h22);
        rd(REG_CONFIG, 32'h0);
        chk("slave_addr_o", 32'h40, saddr);
        chk("i2c_mode_o", 32'h0, i2c);
        chk("profile", PROFILE_ALL, prof);
        wb(REG_PORT, 32'h35, 1'b1, 4'hf);
        settle;
        chk("port_power_ctrl_o", 32'h5, pwr);
        chk("port_charge_enable_o", 32'h3, chg);
        chk("auto_charge_active_o", 32'h1, auto_act);
        @(posedge clk_i);
        fault <= 4'h1;
        settle;
        chk("overcurrent_o", 32'h1, oc);
        wb(REG_CONFIG, 32'h02, 1'b1, 4'hf);
        settle;
        chk("profile", PROFILE_HIGH, prof);
        wb(REG_CONFIG, 32'h00, 1'b1, 4'h0);
        rd(REG_CONFIG, 32'h2);
        wb(REG_CONFIG, 32'h03, 1'b1, 4'hf);
        @(posedge clk_i);
        ss_c <= 1'b1;
        settle;
        chk("ss status", 32'h3, {ss_oe, ss_o});
        chk("hs status", 32'h2, {hs_oe, hs_o});
        @(posedge clk_i);
        ss_c <= 1'b0;
        hs_c <= 1'b1;
        // switch polarity is fixed by the board, other straps move
        straps <= 5'h1f;
        settle;
        chk("ss status", 32'h2, {ss_oe, ss_o});
        chk("hs status", 32'h3, {hs_oe, hs_o});
        rd(REG_STATUS, 32'h421);
        rd(REG_STRAP, 32'h22);
        chk("slave_addr_o", 32'h40, saddr);
        rd(8'h20, 32'h0);
        cfg(5'h15);
        rd(REG_STRAP, 32'h35);
        rd(REG_CONFIG, 32'h2);
        chk("slave_addr_o", 32'h46, saddr);
        wb(REG_PORT, 32'hff, 1'b1, 4'hf);
        settle;
        chk("port_power_ctrl_o", 32'hf, pwr);
        chk("port_charge_enable_o", 32'h0, chg);
        chk("overcurrent_o", 32'h0, oc);
        chk("profile", PROFILE_NONE, prof);
        chk("auto_charge_active_o", 32'h0, auto_act);
        cfg(5'h0c);
        chk("i2c_mode_o", 32'h1, i2c);
        chk("slave_addr_o", SLAVE_ADDR_BASE, saddr);
        wb(REG_PORT, 32'h01, 1'b1, 4'hf);
        @(posedge clk_i);
        fault <= 4'h8;
        settle;
        chk("port_power_ctrl_o", 32'h0, pwr);
        chk("overcurrent_o", 32'hf, oc);
        finish_test;
    end
endmodule // power_switch_strap_config_tb
